// file: logic/sgp_defines.svh
// offsets, reset values and field positions of the six-bit port
`ifndef SGP_DEFINES_SVH
`define SGP_DEFINES_SVH
`define SGP_NPINS 6
`define SGP_IN_ONLY_BIT 3
`define SGP_OFS_PIN_LEVEL_DATA 12'h000
`define SGP_OFS_PIN_DIRECTION 12'h004
`define SGP_OFS_OUTPUT_LATCH 12'h008
`define SGP_OFS_OPEN_DRAIN 12'h00C
`define SGP_OFS_SLEW_LIMIT 12'h010
`define SGP_OFS_THRESHOLD 12'h014
`define SGP_OFS_ANALOG 12'h018
`define SGP_RST_DIRECTION 6'h3F
`define SGP_RST_LATCH 6'h00
`define SGP_RST_OPEN_DRAIN 6'h00
`define SGP_RST_SLEW_LIMIT 6'h3F
`define SGP_RST_THRESHOLD 6'h3F
`define SGP_RST_ANALOG 6'h17
`define SGP_ANALOG_CAPABLE 6'h17
`endif

// file: logic/sgp_pkg.sv
// types of the six-bit port
package sgp_pkg;
  typedef logic [5:0] sgp_bits_t;
  typedef enum logic [6:0] {
    SGP_REG_LEVEL = 7'h01,
    SGP_REG_DIR = 7'h02,
    SGP_REG_LAT = 7'h04,
    SGP_REG_OD = 7'h08,
    SGP_REG_SLEW = 7'h10,
    SGP_REG_THR = 7'h20,
    SGP_REG_ANA = 7'h40
  } sgp_reg_t;
endpackage

// file: logic/sgp_port.sv
// six-bit general purpose port with apb register slave
`timescale 1ns/1ps
`include "sgp_defines.svh"
////////////////////////////////////////////////////////////////////////////////
module sgp_port #(
  parameter int NPINS = `SGP_NPINS
) (
  input wire logic mclk,
  input wire logic rst_n,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic [NPINS-1:0] pin_in,
  output logic [NPINS-1:0] pin_out,
  output logic [NPINS-1:0] pin_oe,
  output logic [NPINS-1:0] pin_slew_limit,
  output logic [NPINS-1:0] pin_schmitt_sel,
  output logic [NPINS-1:0] pin_digital_in,
  output logic [NPINS-1:0] pin_change
);

  ////////////////////////////////////////////////////////////////////////////
  // address decode, shared by read and write paths
  function automatic sgp_pkg::sgp_reg_t sgp_decode(input logic [11:0] a, output logic hit);
    sgp_pkg::sgp_reg_t r;
    r = sgp_pkg::SGP_REG_LEVEL;
    hit = 1'b1;
    if (a == `SGP_OFS_PIN_LEVEL_DATA) begin
      r = sgp_pkg::SGP_REG_LEVEL;
    end else if (a == `SGP_OFS_PIN_DIRECTION) begin
      r = sgp_pkg::SGP_REG_DIR;
    end else if (a == `SGP_OFS_OUTPUT_LATCH) begin
      r = sgp_pkg::SGP_REG_LAT;
    end else if (a == `SGP_OFS_OPEN_DRAIN) begin
      r = sgp_pkg::SGP_REG_OD;
    end else if (a == `SGP_OFS_SLEW_LIMIT) begin
      r = sgp_pkg::SGP_REG_SLEW;
    end else if (a == `SGP_OFS_THRESHOLD) begin
      r = sgp_pkg::SGP_REG_THR;
    end else if (a == `SGP_OFS_ANALOG) begin
      r = sgp_pkg::SGP_REG_ANA;
    end else begin
      hit = 1'b0;
    end
    return r;
  endfunction

  ////////////////////////////////////////////////////////////////////////////
  // pin synchronisers: three stages, change accepted when stages two and three agree
  logic [NPINS-1:0] sync1_r, sync2_r, sync3_r, level_r;
  logic [NPINS-1:0] level_nxt;
  logic [NPINS-1:0] dir_r, lat_r, od_r, slew_r, thr_r, ana_r;
  logic [NPINS-1:0] dir_nxt, lat_nxt, od_nxt, slew_nxt, thr_nxt, ana_nxt;
  logic [NPINS-1:0] dig_in;
  logic [NPINS-1:0] out_nxt, oe_nxt, chg_nxt;
  logic [31:0] prdata_nxt;
  logic pready_nxt, pslverr_nxt;
  sgp_pkg::sgp_reg_t sel;
  logic hit;
  logic access;
  logic [NPINS-1:0] wbits;

  genvar g;
  generate
    for (g = 0; g < NPINS; g++) begin : g_level
      // a one-stage disagreement is treated as metastable and held off
      assign level_nxt[g] = (sync2_r[g] == sync3_r[g]) ? sync3_r[g] : level_r[g];
      // analog pins read zero digitally
      assign dig_in[g] = level_r[g] & ~ana_r[g];
    end
  endgenerate

  ////////////////////////////////////////////////////////////////////////////
  // register file next values
  always_comb begin
    sel = sgp_decode(paddr, hit);
    access = psel & penable & ~pready;
    wbits = pwdata[NPINS-1:0];
    dir_nxt = dir_r;
    lat_nxt = lat_r;
    od_nxt = od_r;
    slew_nxt = slew_r;
    thr_nxt = thr_r;
    ana_nxt = ana_r;
    prdata_nxt = 32'h0000_0000;
    pready_nxt = access;
    pslverr_nxt = access & ~hit;
    if (access & hit & pwrite) begin
      case (sel)
        // a write to the level register loads all six bits into the output latch, as a latch write does
        sgp_pkg::SGP_REG_LEVEL: lat_nxt = wbits;
        sgp_pkg::SGP_REG_DIR: dir_nxt = wbits;
        sgp_pkg::SGP_REG_LAT: lat_nxt = wbits;
        sgp_pkg::SGP_REG_OD: od_nxt = wbits;
        sgp_pkg::SGP_REG_SLEW: slew_nxt = wbits;
        sgp_pkg::SGP_REG_THR: thr_nxt = wbits;
        sgp_pkg::SGP_REG_ANA: ana_nxt = wbits & `SGP_ANALOG_CAPABLE;
        default: lat_nxt = lat_r;
      endcase
    end
    // input-only pin never gets an output driver
    dir_nxt[`SGP_IN_ONLY_BIT] = 1'b1;
    if (access & hit & ~pwrite) begin
      case (sel)
        sgp_pkg::SGP_REG_LEVEL: prdata_nxt[NPINS-1:0] = dig_in;
        sgp_pkg::SGP_REG_DIR: prdata_nxt[NPINS-1:0] = dir_r;
        sgp_pkg::SGP_REG_LAT: prdata_nxt[NPINS-1:0] = lat_r;
        sgp_pkg::SGP_REG_OD: prdata_nxt[NPINS-1:0] = od_r;
        sgp_pkg::SGP_REG_SLEW: prdata_nxt[NPINS-1:0] = slew_r;
        sgp_pkg::SGP_REG_THR: prdata_nxt[NPINS-1:0] = thr_r;
        sgp_pkg::SGP_REG_ANA: prdata_nxt[NPINS-1:0] = ana_r;
        default: prdata_nxt = 32'h0000_0000;
      endcase
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // pad drive next values
  always_comb begin
    // direction decides the driver, analog select plays no part
    oe_nxt = ~dir_nxt;
    // open drain: drive only while the latch is low, release otherwise
    oe_nxt = oe_nxt & ~(od_nxt & lat_nxt);
    out_nxt = lat_nxt & ~od_nxt;
    // change detect on thresholded digital level
    chg_nxt = (level_nxt ^ level_r) & ~ana_r;
  end

  ////////////////////////////////////////////////////////////////////////////
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      sync1_r <= '0;
      sync2_r <= '0;
      sync3_r <= '0;
      level_r <= '0;
      dir_r <= `SGP_RST_DIRECTION;
      lat_r <= `SGP_RST_LATCH;
      od_r <= `SGP_RST_OPEN_DRAIN;
      slew_r <= `SGP_RST_SLEW_LIMIT;
      thr_r <= `SGP_RST_THRESHOLD;
      ana_r <= `SGP_RST_ANALOG;
      prdata <= 32'h0000_0000;
      pready <= 1'b0;
      pslverr <= 1'b0;
      pin_out <= '0;
      pin_oe <= '0;
      pin_slew_limit <= `SGP_RST_SLEW_LIMIT;
      pin_schmitt_sel <= `SGP_RST_THRESHOLD;
      pin_digital_in <= '0;
      pin_change <= '0;
    end else begin
      sync1_r <= pin_in;
      sync2_r <= sync1_r;
      sync3_r <= sync2_r;
      level_r <= level_nxt;
      dir_r <= dir_nxt;
      lat_r <= lat_nxt;
      od_r <= od_nxt;
      slew_r <= slew_nxt;
      thr_r <= thr_nxt;
      ana_r <= ana_nxt;
      prdata <= prdata_nxt;
      pready <= pready_nxt;
      pslverr <= pslverr_nxt;
      pin_out <= out_nxt;
      pin_oe <= oe_nxt;
      pin_slew_limit <= slew_nxt;
      pin_schmitt_sel <= thr_nxt;
      pin_digital_in <= level_nxt & ~ana_nxt;
      pin_change <= chg_nxt;
    end
  end

endmodule // sgp_port

// file: verif/sgp_port_chk.sv
// assertions on the apb answer and pin outputs of the six-bit port
`timescale 1ns/1ps
module sgp_port_chk #(
  parameter int NPINS = 6
) (
  input wire logic mclk,
  input wire logic rst_n,
  input wire logic psel,
  input wire logic penable,
  input wire logic [31:0] prdata,
  input wire logic pready,
  input wire logic pslverr,
  input wire logic [NPINS-1:0] pin_in,
  input wire logic [NPINS-1:0] pin_oe,
  input wire logic [NPINS-1:0] pin_slew_limit,
  input wire logic [NPINS-1:0] pin_schmitt_sel,
  input wire logic [NPINS-1:0] pin_digital_in,
  input wire logic [NPINS-1:0] pin_change
);
  default clocking @(posedge mclk); endclocking
  default disable iff (!rst_n);
  chk_ready_wait: assert property (psel && penable && !pready |=> pready)
    else $error("no answer after wait");
  chk_ready_pulse: assert property (pready |=> !pready) else $error("ready held");
  chk_err_ready: assert property (pslverr |-> pready) else $error("error alone");
  chk_idle_data: assert property (!pready |-> prdata == 32'h0)
    else $error("data outside answer");
  chk_pin3_input: assert property (!pin_oe[3]) else $error("pin three driven");
  // pin five has no analog mode, so its level always passes
  chk_level_follow: assert property ($stable(pin_in[5])[*6] |-> pin_digital_in[5] == pin_in[5])
    else $error("level not followed");
  chk_change_edge: assert property (pin_change[5] |-> $changed(pin_digital_in[5]))
    else $error("change without edge");
  chk_reset_vals: assert property ($rose(rst_n) |-> pin_slew_limit == 6'h3F
    && pin_schmitt_sel == 6'h3F && pin_oe == 6'h00) else $error("bad reset outputs");
  cover property (pslverr);
  cover property (pin_change[5]);
  cover property (pready && pin_oe != 6'h00);
endmodule // sgp_port_chk
////////////////////////////////////////////////////////////////////////////////
bind sgp_port sgp_port_chk #(.NPINS(NPINS)) u_chk (.mclk(mclk), .rst_n(rst_n), .psel(psel),
  .penable(penable), .prdata(prdata), .pready(pready), .pslverr(pslverr), .pin_in(pin_in),
  .pin_oe(pin_oe), .pin_slew_limit(pin_slew_limit), .pin_schmitt_sel(pin_schmitt_sel),
  .pin_digital_in(pin_digital_in), .pin_change(pin_change));

// file: verif/sgp_pads.sv
// pad model: driven pins show the output, released pins the board level
`timescale 1ns/1ps
module sgp_pads (
  input wire logic [5:0] pin_out,
  input wire logic [5:0] pin_oe,
  input wire logic [5:0] board_level,
  output logic [5:0] pin_in
);
  // released open-drain pads fall back to the board's level, not the last value
  assign pin_in = (pin_oe & pin_out) | (~pin_oe & board_level);
endmodule // sgp_pads

// file: verif/six_bit_gpio_port_control_tb.sv
// random and corner tests of the six-bit port
`timescale 1ns/1ps
`include "sgp_defines.svh"
module six_bit_gpio_port_control_tb;
  logic mclk, rst_n, psel, penable, pwrite, pready, pslverr, e;
  logic [11:0] paddr;
  logic [31:0] pwdata, prdata, q;
  logic [5:0] pin_in, pin_out, pin_oe, slew, schm, din, board, r, v;
  int errors, cmp_count, cyc;
  logic [11:0] ofs [6] = '{`SGP_OFS_PIN_DIRECTION, `SGP_OFS_OUTPUT_LATCH, `SGP_OFS_OPEN_DRAIN,
    `SGP_OFS_SLEW_LIMIT, `SGP_OFS_THRESHOLD, `SGP_OFS_ANALOG};
  logic [5:0] rv [6] = '{`SGP_RST_DIRECTION, `SGP_RST_LATCH, `SGP_RST_OPEN_DRAIN,
    `SGP_RST_SLEW_LIMIT, `SGP_RST_THRESHOLD, `SGP_RST_ANALOG};
  sgp_port uut (.mclk(mclk), .rst_n(rst_n), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .pin_in(pin_in), .pin_out(pin_out), .pin_oe(pin_oe), .pin_slew_limit(slew),
    .pin_schmitt_sel(schm), .pin_digital_in(din), .pin_change());
  sgp_pads pads (.pin_out(pin_out), .pin_oe(pin_oe), .board_level(board), .pin_in(pin_in));
  initial begin
    mclk = 0;
    forever #20 mclk = ~mclk;
  end
  ////////////////////////////////////////////////////////////////////////////////
  function automatic logic [5:0] exp_lvl(logic [5:0] lvl, logic [5:0] ana);
    return lvl & ~(ana & `SGP_ANALOG_CAPABLE);
  endfunction
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    cmp_count++;
    if (got !== exp) begin
      errors++;
      $display("FAIL t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  // one idle edge first, so a request is never raised at the edge that dropped it
  task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] d);
    int n;
    @(posedge mclk);
    psel <= 1;
    pwrite <= wr;
    paddr <= a;
    pwdata <= d;
    n = 0;
    @(posedge mclk);
    penable <= 1;
    do begin
      @(posedge mclk);
      n++;
    end while (pready !== 1'b1 && n < 20);
    if (pready !== 1'b1) begin
      errors++;
      $display("FAIL t=%0t got=%h exp=%h", $time, pready, 1'b1);
    end
    q = prdata;
    e = pslverr;
    psel <= 0;
    penable <= 0;
  endtask
  task automatic rd(input logic [11:0] a, input logic [31:0] x);
    apb(0, a, 0);
    chk(q, x);
  endtask
  task automatic wr(input logic [11:0] a, input logic [5:0] d);
    apb(1, a, 32'(d));
  endtask
  task automatic report_and_stop;
    $display("compares %0d mismatches %0d", cmp_count, errors);
    if (errors == 0 && cmp_count > 0)
      $display("No errors found");
    else
      $display("Errors were found");
    $finish;
  endtask
  always @(posedge mclk) begin
    cyc++;
    if (cyc == 20000) begin
      errors++;
      report_and_stop;
    end
  end
  ////////////////////////////////////////////////////////////////////////////////
  initial begin
    {rst_n, psel, penable, pwrite, paddr, pwdata, errors, cmp_count, cyc} = '0;
    board = 6'h2A;
    r = 6'($urandom(31));
    repeat (5) @(posedge mclk);
    rst_n <= 1;
    for (int i = 0; i < 6; i++) rd(ofs[i], 32'(rv[i]));
    rd(12'h01C, 0);
    chk(32'(e), 1);
    $display("test reset done");
    wr(`SGP_OFS_PIN_DIRECTION, 0);
    rd(`SGP_OFS_PIN_DIRECTION, 32'h08);
    for (int t = 0; t < 4; t++) begin
      r = 6'($urandom);
      v = 6'($urandom);
      wr(`SGP_OFS_OPEN_DRAIN, v);
      wr(`SGP_OFS_ANALOG, v);
      wr(`SGP_OFS_OUTPUT_LATCH, r);
      rd(`SGP_OFS_OUTPUT_LATCH, 32'(r));
      chk(32'(pin_oe), 32'(6'h37 & ~(v & r)));
      chk(32'(pin_out & pin_oe), 32'(r & ~v & 6'h37));
      wr(`SGP_OFS_SLEW_LIMIT, r);
      wr(`SGP_OFS_THRESHOLD, v);
      chk(32'(slew), 32'(r));
      chk(32'(schm), 32'(v));
    end
    $display("test drive done");
    wr(`SGP_OFS_PIN_DIRECTION, 6'h3F);
    chk(32'(pin_oe), 0);
    for (int t = 0; t < 6; t++) begin
      r = (t < 2) ? 6'h00 : 6'($urandom);
      v = 6'($urandom);
      wr(`SGP_OFS_ANALOG, r);
      board <= v;
      repeat (6) @(posedge mclk);
      rd(`SGP_OFS_PIN_LEVEL_DATA, 32'(exp_lvl(v, r)));
      chk(32'(din), 32'(exp_lvl(v, r)));
      wr(`SGP_OFS_PIN_LEVEL_DATA, v ^ r);
      rd(`SGP_OFS_OUTPUT_LATCH, 32'(v ^ r));
    end
    $display("test input done");
    report_and_stop;
  end
endmodule // six_bit_gpio_port_control_tb
